// ---- inc/csf_pkg.sv ----
// Package for the CPU status-flag block: flag byte layout, opcodes,
// condition codes, register offsets and timing counts.
// Assumes a single 50 MHz system clock shared with the sequencer.
`default_nettype none

package csf_pkg;

	////////////////////////////////////////////////////////////////////
	// Flag byte bit positions, most significant first
	localparam int unsigned FLAG_C   = 7;
	localparam int unsigned FLAG_Z   = 6;
	localparam int unsigned FLAG_S   = 5;
	localparam int unsigned FLAG_V   = 4;
	localparam int unsigned FLAG_D   = 3;
	localparam int unsigned FLAG_H   = 2;
	localparam int unsigned FLAG_U2  = 1;
	localparam int unsigned FLAG_U1  = 0;
	localparam logic [7:0]  ARITH_MASK  = 8'hfc;
	localparam logic [7:0]  USER_MASK   = 8'h03;
	localparam logic [5:0]  ARITH_RESET = 6'h00;

	////////////////////////////////////////////////////////////////////
	// Extended exclusive-or opcodes and timing
	localparam logic [7:0]  XOR_OP_REG  = 8'hb8;
	localparam logic [7:0]  XOR_OP_IMM  = 8'hb9;
	localparam int unsigned XOR_BYTES   = 4;
	localparam int unsigned XOR_CYCLES  = 3;

	////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [3:0]  REG_FLAGS   = 4'h0;
	localparam logic [3:0]  REG_RESULT  = 4'h4;
	localparam logic [3:0]  REG_COND    = 4'h8;

	////////////////////////////////////////////////////////////////////
	// Jump condition codes
	typedef enum logic [3:0] {
		CC_NEVER, CC_LT, CC_LE, CC_ULE, CC_OV, CC_MI, CC_EQ, CC_CY,
		CC_ALWAYS, CC_GE, CC_GT, CC_UGT, CC_NOV, CC_PL, CC_NE, CC_NC
	} csf_cc_t;

endpackage : csf_pkg

`default_nettype wire

// ---- design/csf_flags.sv ----
// CPU status-flag logic: six arithmetic flags, two user flags, jump
// condition evaluation, extended exclusive-or, stack save and restore.
// Assumes sequencer strobes are one-cycle pulses on MCLK and a classic
// Wishbone master for software access.
//
// Notes on behaviour
// [RULE1] Extended xor writes dst xor src; b8 uses a register source, b9 an immediate.
// [RULE2] Extended xor sets zero and sign from the result, clears overflow, keeps C, D, H; 4 bytes, 3 cycles.
// [RULE3] Six status bits are set or cleared by the latest arithmetic or logic result.
// [RULE4] Carry, overflow, zero and sign are testable by conditional jumps.
// [RULE5] Half-carry and decimal-adjust are never jump conditions.
// [RULE6] User flags change only on explicit set, clear or load, never by arithmetic.
// [RULE7] User flags are never jump conditions.
// [RULE8] User flags have no reset value and reset leaves them alone.
// [RULE9] Interrupt, software trap and illegal trap entry push the flag byte.
// [RULE10] Interrupt return reloads the whole flag byte from the stack.
// [RULE11] Flag byte order from bit 7: C, Z, S, V, D, H, user two, user one.
`default_nettype none

module csf_flags
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// Wishbone classic slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Generic flag update from the ALU
	input  wire logic        ALU_UPD,
	input  wire logic [5:0]  ALU_MASK,
	input  wire logic [5:0]  ALU_FLAGS,
	// Explicit user flag instructions
	input  wire logic [1:0]  USER_SET,
	input  wire logic [1:0]  USER_CLR,
	// Extended exclusive-or
	input  wire logic        XOR_GO,
	input  wire logic [7:0]  XOR_OPCODE,
	input  wire logic [7:0]  XOR_DST,
	input  wire logic [7:0]  XOR_SRC,
	input  wire logic [7:0]  XOR_IMM,
	output logic             XOR_BUSY,
	output logic             XOR_DONE,
	output logic      [7:0]  XOR_RESULT,
	// Jump conditions
	input  wire logic [3:0]  JMP_CC,
	output logic             JMP_TAKE,
	output logic             COND_C,
	output logic             COND_Z,
	output logic             COND_S,
	output logic             COND_V,
	// Stack save and restore
	input  wire logic        TRAP_ENTRY,
	output logic             PUSH_STB,
	output logic      [7:0]  PUSH_DATA,
	input  wire logic        INT_RET_LOAD,
	input  wire logic [7:0]  POP_DATA,
	output logic      [7:0]  FLAGS
);

	////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Condition evaluation; only C, Z, S and V enter the decode
	function automatic logic cc_eval(input logic [3:0] cc,
		input logic c, input logic z, input logic s, input logic v);
		logic r;
		r = 1'b0;
		case (csf_pkg::csf_cc_t'(cc))
			csf_pkg::CC_NEVER:  r = 1'b0;
			csf_pkg::CC_LT:     r = s ^ v;
			csf_pkg::CC_LE:     r = z | (s ^ v);
			csf_pkg::CC_ULE:    r = c | z;
			csf_pkg::CC_OV:     r = v;
			csf_pkg::CC_MI:     r = s;
			csf_pkg::CC_EQ:     r = z;
			csf_pkg::CC_CY:     r = c;
			csf_pkg::CC_ALWAYS: r = 1'b1;
			csf_pkg::CC_GE:     r = ~(s ^ v);
			csf_pkg::CC_GT:     r = ~(z | (s ^ v));
			csf_pkg::CC_UGT:    r = ~c & ~z;
			csf_pkg::CC_NOV:    r = ~v;
			csf_pkg::CC_PL:     r = ~s;
			csf_pkg::CC_NE:     r = ~z;
			csf_pkg::CC_NC:     r = ~c;
			default:            r = 1'b0;
		endcase
		return r;
	endfunction : cc_eval

	////////////////////////////////////////////////////////////////////
	// Extended exclusive-or sequencer
	typedef enum logic {CSF_IDLE, CSF_RUN} csf_xst_t;

	csf_xst_t   xst_q, xst_d;
	logic [1:0] xcnt_q, xcnt_d;
	logic [7:0] xres_q, xres_d;
	logic       xdone_q, xdone_d;
	logic       xor_take;

	// Opcodes other than the two xor forms are ignored
	assign xor_take = XOR_GO && xst_q == CSF_IDLE &&
		(XOR_OPCODE == csf_pkg::XOR_OP_REG ||
		 XOR_OPCODE == csf_pkg::XOR_OP_IMM);

	always_comb
	begin
		xst_d   = xst_q;
		xcnt_d  = xcnt_q;
		xres_d  = xres_q;
		xdone_d = 1'b0;
		case (xst_q)
			CSF_IDLE:
			begin
				if (xor_take)
				begin
					xres_d = XOR_DST ^ ((XOR_OPCODE == csf_pkg::XOR_OP_IMM) ?
						XOR_IMM : XOR_SRC); // [RULE1]
					xcnt_d = 2'h1;
					xst_d  = CSF_RUN;
				end
			end
			CSF_RUN:
			begin
				// Done is posted on the third cycle of the op; the result register loads when the op is taken
				if (xcnt_q == 2'(csf_pkg::XOR_CYCLES - 1)) // [RULE2]
				begin
					xdone_d = 1'b1;
					xst_d   = CSF_IDLE;
					xcnt_d  = 2'h0;
				end
				else
					xcnt_d = xcnt_q + 2'h1;
			end
			default:
			begin
				xst_d  = CSF_IDLE;
				xcnt_d = 2'h0;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			xst_q   <= CSF_IDLE;
			xcnt_q  <= 2'h0;
			xres_q  <= 8'h00;
			xdone_q <= 1'b0;
		end
		else
		begin
			xst_q   <= xst_d;
			xcnt_q  <= xcnt_d;
			xres_q  <= xres_d;
			xdone_q <= xdone_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after the request, writes at that edge
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        wb_req;
	logic        sw_flag_wr;
	logic [7:0]  flags;

	assign wb_req     = WB_CYC_I && WB_STB_I && !ack_q;
	assign sw_flag_wr = wb_req && WB_WE_I && WB_SEL_I[0] &&
		WB_ADR_I == csf_pkg::REG_FLAGS;

	always_comb
	begin
		ack_d  = wb_req;
		rdat_d = 32'h0000_0000;
		if (wb_req && !WB_WE_I)
		begin
			case (WB_ADR_I)
				csf_pkg::REG_FLAGS:  rdat_d = {24'h00_0000, flags};
				csf_pkg::REG_RESULT: rdat_d = {24'h00_0000, xres_q};
				csf_pkg::REG_COND:   rdat_d = {28'h000_0000, COND_C,
					COND_Z, COND_S, COND_V};
				default:             rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Arithmetic flags C Z S V D H, held as flags[7:2]
	logic [5:0] arith_q, arith_d;
	logic [5:0] xor_mask;
	logic [5:0] xor_val;

	// Field order matches the flag byte from bit 7 downward
	assign xor_mask = 6'h1c;
	assign xor_val  = {1'b0, xres_q == 8'h00, xres_q[7], 1'b0, 2'h0};

	always_comb
	begin
		arith_d = arith_q;
		if (INT_RET_LOAD)
			arith_d = POP_DATA[7:2]; // [RULE10]
		else if (sw_flag_wr)
			arith_d = WB_DAT_I[7:2];
		else if (xdone_q)
			arith_d = (arith_q & ~xor_mask) | xor_val; // [RULE2]
		else if (ALU_UPD)
			arith_d = (arith_q & ~ALU_MASK) | (ALU_FLAGS & ALU_MASK); // [RULE3]
	end

	always_ff @(posedge MCLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
			arith_q <= csf_pkg::ARITH_RESET;
		else
			arith_q <= arith_d;
	end

	////////////////////////////////////////////////////////////////////
	// User flags: no reset on purpose, so power-up value is unknown
	logic [1:0] user_q, user_d;

	always_comb
	begin
		user_d = user_q; // [RULE6]
		if (INT_RET_LOAD)
			user_d = POP_DATA[1:0]; // [RULE10]
		else if (sw_flag_wr)
			user_d = WB_DAT_I[1:0]; // [RULE6]
		else
			user_d = (user_q | USER_SET) & ~USER_CLR; // [RULE6]
	end

	always_ff @(posedge MCLK)
	begin
		user_q <= user_d; // [RULE8]
	end

	assign flags = {arith_q, user_q}; // [RULE11]

	////////////////////////////////////////////////////////////////////
	// Flag byte push on trap or interrupt entry
	logic       push_q, push_d;
	logic [7:0] pdat_q, pdat_d;

	always_comb
	begin
		push_d = TRAP_ENTRY; // [RULE9]
		pdat_d = TRAP_ENTRY ? flags : pdat_q; // [RULE9]
	end

	always_ff @(posedge MCLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			push_q <= 1'b0;
			pdat_q <= 8'h00;
		end
		else
		begin
			push_q <= push_d;
			pdat_q <= pdat_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs; D, H and the user flags never reach the condition decode
	assign COND_C     = arith_q[csf_pkg::FLAG_C - 2]; // [RULE4]
	assign COND_Z     = arith_q[csf_pkg::FLAG_Z - 2]; // [RULE4]
	assign COND_S     = arith_q[csf_pkg::FLAG_S - 2]; // [RULE4]
	assign COND_V     = arith_q[csf_pkg::FLAG_V - 2]; // [RULE4]
	assign JMP_TAKE   = cc_eval(JMP_CC, COND_C, COND_Z, COND_S,
		COND_V); // [RULE5] [RULE7]
	assign WB_ACK_O   = ack_q;
	assign WB_DAT_O   = rdat_q;
	assign XOR_BUSY   = xst_q == CSF_RUN;
	assign XOR_DONE   = xdone_q;
	assign XOR_RESULT = xres_q;
	assign PUSH_STB   = push_q;
	assign PUSH_DATA  = pdat_q;
	assign FLAGS      = flags;

endmodule : csf_flags

`default_nettype wire

// ---- sim/csf_flags_chk.sv ----
// Assertion checker for the status-flag block, bound to its top module.
// Assumes one clock domain and the active-low block reset.
`default_nettype none

module csf_flags_chk
(
	input wire logic       MCLK,
	input wire logic       RST_N,
	input wire logic       WB_CYC_I,
	input wire logic       ALU_UPD,
	input wire logic [1:0] USER_SET,
	input wire logic [1:0] USER_CLR,
	input wire logic       XOR_GO,
	input wire logic [7:0] XOR_OPCODE,
	input wire logic       XOR_BUSY,
	input wire logic       XOR_DONE,
	input wire logic [7:0] XOR_RESULT,
	input wire logic [3:0] JMP_CC,
	input wire logic       JMP_TAKE,
	input wire logic       TRAP_ENTRY,
	input wire logic       PUSH_STB,
	input wire logic [7:0] PUSH_DATA,
	input wire logic       INT_RET_LOAD,
	input wire logic [7:0] POP_DATA,
	input wire logic [7:0] FLAGS
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////
	// Both accepted opcodes differ only in bit 0
	sequence s_xor_take;
		XOR_GO && !XOR_BUSY && XOR_OPCODE[7:1] == 7'h5c;
	endsequence
	sequence s_xor_run;
		XOR_BUSY [*2] ##1 (XOR_DONE && !XOR_BUSY);
	endsequence
	a_xor_done_delay: assert property (s_xor_take |=> s_xor_run)
		else $error("xor completion off its cycle count");
	a_xor_flags: assert property (XOR_DONE && !INT_RET_LOAD
		&& !WB_CYC_I |=>
		FLAGS[6:4] == {$past(XOR_RESULT) == 8'h00, $past(XOR_RESULT[7]), 1'h0}
		&& (FLAGS & 8'h8c) == ($past(FLAGS) & 8'h8c))
		else $error("xor flag update wrong");
	a_push_after_trap: assert property (TRAP_ENTRY |=> PUSH_STB
		&& PUSH_DATA == $past(FLAGS)) else $error("flag byte not pushed");
	a_ret_reload: assert property (INT_RET_LOAD |=>
		FLAGS == $past(POP_DATA))
		else $error("flag byte not restored");
	a_jmp_hidden_flags: assert property ($stable(JMP_CC)
		&& FLAGS[7:4] == $past(FLAGS[7:4]) |-> $stable(JMP_TAKE))
		else $error("jump depends on an untestable flag");
	a_jmp_carry: assert property (JMP_CC == 4'h7 |-> JMP_TAKE == FLAGS[7])
		else $error("carry condition wrong");
	a_user_keep: assert property (ALU_UPD && !(|USER_SET) && !(|USER_CLR)
		&& !INT_RET_LOAD && !WB_CYC_I |=>
		FLAGS[1:0] == $past(FLAGS[1:0]))
		else $error("user flags moved by arithmetic");
	a_user_set_clear: assert property (|(USER_SET | USER_CLR)
		&& !INT_RET_LOAD && !WB_CYC_I |=> FLAGS[1:0] ==
		(($past(FLAGS[1:0]) | $past(USER_SET)) & ~$past(USER_CLR)))
		else $error("user flag instruction wrong");
endmodule : csf_flags_chk

bind csf_flags csf_flags_chk i_csf_flags_chk (.*);

`default_nettype wire

// ---- sim/csf_stack_mdl.sv ----
// Stack partner: keeps pushed flag bytes and hands one back on request.
// Assumes a return is requested only after a push.
`default_nettype none

module csf_stack_mdl
(
	input  wire logic       mclk,
	input  wire logic       push_stb,
	input  wire logic [7:0] push_data,
	input  wire logic       ret_req,
	output logic            int_ret_load,
	output logic      [7:0] pop_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] stk [$];

	initial {int_ret_load, pop_data} = 9'h05a;
	// Outside a return the byte toggles so a stale value cannot pass
	always @(posedge mclk)
	begin
		if (push_stb)
			stk.push_back(push_data);
		int_ret_load <= ret_req && stk.size() > 0;
		if (ret_req && stk.size() > 0)
			pop_data <= stk.pop_back();
		else
			pop_data <= ~pop_data;
	end
endmodule : csf_stack_mdl

`default_nettype wire

// ---- sim/csf_flags_tb_top.sv ----
// Bench for the status-flag block with the stack partner beside it.
// Assumes the checker is bound in by its own file.
`default_nettype none

module csf_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        MCLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
	logic        ALU_UPD, XOR_GO, XOR_BUSY, XOR_DONE, JMP_TAKE, ret_req;
	logic        COND_C, COND_Z, COND_S, COND_V, TRAP_ENTRY, PUSH_STB;
	logic        INT_RET_LOAD;
	logic [3:0]  WB_ADR_I, WB_SEL_I, JMP_CC;
	logic [31:0] WB_DAT_I, WB_DAT_O, rd;
	logic [5:0]  ALU_MASK, ALU_FLAGS;
	logic [1:0]  USER_SET, USER_CLR;
	logic [7:0]  XOR_OPCODE, XOR_DST, XOR_SRC, XOR_IMM, XOR_RESULT;
	logic [7:0]  PUSH_DATA, POP_DATA, FLAGS;
	int          n_fail = 0;
	int          comparisons = 0;
	// Mask, flags, expected flags, condition code, jump taken
	logic [31:0] rows [18] = '{32'h3f3f3f71, 32'h20001ff1, 32'h10000fe1,
		32'h08000750, 32'h04000340, 32'h03000000, 32'h03030360,
		32'h30303331, 32'h08083b51, 32'h04043f10, 32'h00003f81,
		32'h00003f21, 32'h04003b90, 32'h180023a1, 32'h200003b1,
		32'h040407c0, 32'h08080fd0, 32'h3f3f3f91};

	csf_flags i_csf_flags (.*);
	csf_stack_mdl i_csf_stack_mdl (.mclk(MCLK), .push_stb(PUSH_STB),
		.push_data(PUSH_DATA), .ret_req(ret_req),
		.int_ret_load(INT_RET_LOAD), .pop_data(POP_DATA));

	initial
	begin
		MCLK = 1'h0;
		forever #10 MCLK = ~MCLK;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'h1);
		@(posedge MCLK);
		{WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'h3, we};
		WB_SEL_I <= s;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		@(posedge MCLK);
		while (WB_ACK_O !== 1'h1)
			@(posedge MCLK);
		rd = WB_DAT_O;
		{WB_CYC_I, WB_STB_I} <= 2'h0;
	endtask : wb

	task automatic alu(input logic [5:0] m, f, input logic [3:0] cc);
		@(posedge MCLK);
		{ALU_UPD, ALU_MASK, ALU_FLAGS, JMP_CC} <= {1'h1, m, f, cc};
		@(posedge MCLK);
		ALU_UPD <= 1'h0;
	endtask : alu

	task automatic xr(input logic [7:0] op, dst, src, imm, res, flg);
		@(posedge MCLK);
		{XOR_GO, XOR_OPCODE, XOR_DST, XOR_SRC, XOR_IMM} <= {1'h1, op, dst, src, imm};
		@(posedge MCLK);
		XOR_GO <= 1'h0;
		#1 chk(XOR_BUSY, op[7:1] == 7'h5c);
		if (op[7:1] == 7'h5c)
		begin
			repeat (2) @(posedge MCLK);
			#1 chk(XOR_DONE, 1'h1);
			@(posedge MCLK);
			#1 chk({XOR_RESULT, FLAGS}, {res, flg});
		end
	endtask : xr

	initial
	begin
		{WB_CYC_I, WB_STB_I, WB_WE_I, ALU_UPD, XOR_GO, TRAP_ENTRY, ret_req} = '0;
		{WB_ADR_I, WB_DAT_I, ALU_MASK, ALU_FLAGS, USER_SET, USER_CLR} = '0;
		{XOR_OPCODE, XOR_DST, XOR_SRC, XOR_IMM, JMP_CC} = '0;
		{WB_SEL_I, RST_N} = 5'h02;
		repeat (12) @(posedge MCLK);
		RST_N <= 1'h1;
		repeat (3) @(posedge MCLK);
		{USER_SET, USER_CLR} <= 4'hd;
		@(posedge MCLK);
		{USER_SET, USER_CLR} <= 4'h0;
		#1 chk(FLAGS[1:0], 2'h2);
		foreach (rows[i])
		begin
			alu(rows[i][29:24], rows[i][21:16], rows[i][7:4]);
			#1 chk(FLAGS, {rows[i][13:8], 2'h2});
			chk(JMP_TAKE, rows[i][0]);
		end
		wb(1'h0, csf_pkg::REG_FLAGS, 32'h0);
		chk(rd, 32'hfe);
		wb(1'h0, csf_pkg::REG_COND, 32'h0);
		chk(rd, 32'hf);
		wb(1'h1, csf_pkg::REG_FLAGS, 32'h41);
		wb(1'h1, csf_pkg::REG_FLAGS, 32'hff, 4'h0);
		wb(1'h1, 4'hc, 32'hff);
		wb(1'h0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		#1 chk({COND_C, COND_Z, COND_S, COND_V, FLAGS}, 12'h441);
		alu(6'h3f, 6'h2f, 4'h8);
		xr(csf_pkg::XOR_OP_REG, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'hcd);
		xr(csf_pkg::XOR_OP_IMM, 8'h0f, 8'hff, 8'h80, 8'h8f, 8'had);
		xr(8'hb7, 8'h0f, 8'hff, 8'h80, 8'h8f, 8'had);
		wb(1'h0, csf_pkg::REG_RESULT, 32'h0);
		chk(rd, 32'h8f);
		@(posedge MCLK);
		TRAP_ENTRY <= 1'h1;
		@(posedge MCLK);
		TRAP_ENTRY <= 1'h0;
		#1 chk({PUSH_STB, PUSH_DATA}, 9'h1ad);
		alu(6'h3f, 6'h00, 4'h8);
		@(posedge MCLK);
		ret_req <= 1'h1;
		@(posedge MCLK);
		ret_req <= 1'h0;
		@(posedge MCLK);
		#1 chk(FLAGS, 8'had);
		@(posedge MCLK);
		RST_N <= 1'h0;
		repeat (2) @(posedge MCLK);
		RST_N <= 1'h1;
		#1 chk(FLAGS, 8'h01);
		repeat (3) @(posedge MCLK);
		#1 chk(FLAGS, 8'h01);
		give_verdict();
	end

	initial
	begin
		repeat (1000) @(posedge MCLK);
		n_fail++;
		give_verdict();
	end
endmodule : csf_flags_tb_top

`default_nettype wire
